// ===== rtl/servo_pid_map.vh
`ifndef SERVO_PID_MAP_VH
`define SERVO_PID_MAP_VH

// Command byte codes
`define CMD_RESET 8'h00
`define CMD_BEGIN 8'h01
`define CMD_HOME 8'h02
`define CMD_INDEX_ARM 8'h03
`define CMD_FILTER_APPLY 8'h04
`define CMD_NARROW 8'h05
`define CMD_WIDE 8'h06
`define CMD_DES_VEL 8'h07
`define CMD_DES_POS 8'h08
`define CMD_IDX_POS 8'h09
`define CMD_ACT_POS 8'h0a
`define CMD_ACT_VEL 8'h0b
`define CMD_SIGNALS 8'h0c
`define CMD_INT_SUM 8'h0d
`define CMD_HALT_THR 8'h1a
`define CMD_ALERT_THR 8'h1b
`define CMD_INT_MASK 8'h1c
`define CMD_INT_CLEAR 8'h1d
`define CMD_FILTER_LOAD 8'h1e
`define CMD_TRAJ_LOAD 8'h1f
`define CMD_BKPT_ABS 8'h20
`define CMD_BKPT_REL 8'h21

// Status byte bit positions
`define ST_BUSY 0
`define ST_INDEX 3
`define ST_ERR 5
`define ST_BKPT 6
`define ST_OFF 7

// Filter and trajectory control word fields
`define FC_KP 3
`define FC_KI 2
`define FC_KD 1
`define FC_IL 0
`define TC_ACC 5
`define TC_VEL 3
`define TC_POS 1

// Offset-binary zero codes, saturation limits and reset values
`define ZERO8 8'h80
`define ZERO12 12'h800
`define SAT_POS 16'h7fff
`define SAT_NEG 16'h8000
`define CLR16 16'h0000
`define CLR32 32'h0000_0000

// Timing
`define CLK_KHZ 40000
`define BUSY_NS 20000
`define SAMPLE_CLKS 2048
`define WIDE_HOLD_CLKS 16

`endif

// ===== rtl/pid_filter.v
`timescale 1ns/1ps
`include "servo_pid_map.vh"

module pid_filter (
  input wire sys_clk,
  input wire reset_n,
  input wire clear,
  input wire sample_tick,
  input wire deriv_tick,
  input wire [15:0] err,
  input wire [15:0] proportional_gain,
  input wire [15:0] integral_gain,
  input wire [15:0] derivative_gain,
  input wire [15:0] integral_limit,
  output reg [15:0] ctrl_out,
  output wire [15:0] integral_sum
);
  reg [23:0] accum;
  reg [15:0] prev_err;
  reg [15:0] d_term;
  reg out_tick;
  wire [15:0] diff = err - prev_err;
  wire [15:0] i_op = {{8{accum[23]}}, accum[23:16]};
  wire [31:0] p_full = $signed(err) * $signed(proportional_gain);
  wire [31:0] i_full = $signed(i_op) * $signed(integral_gain);
  wire [31:0] d_full = $signed(diff) * $signed(derivative_gain);
  wire [15:0] p_term = p_full[15:0];
  wire [15:0] i_prod = i_full[15:0];
  wire [15:0] i_mag = i_prod[15] ? (`CLR16 - i_prod) : i_prod;
  wire [15:0] i_lim = (i_mag > integral_limit) ? integral_limit : i_mag;
  wire [15:0] i_term = i_prod[15] ? (`CLR16 - i_lim) : i_lim;

  assign integral_sum = accum[23:8];

  // Accumulate every sample, difference only at derivative rate
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      accum <= 24'h00_0000;
      prev_err <= `CLR16;
      d_term <= `CLR16;
      out_tick <= 1'b0;
      ctrl_out <= `CLR16;
    end else if (clear) begin
      accum <= 24'h00_0000;
      prev_err <= `CLR16;
      d_term <= `CLR16;
      out_tick <= 1'b0;
      ctrl_out <= `CLR16;
    end else begin
      out_tick <= sample_tick;
      if (sample_tick) begin
        accum <= accum + {{8{err[15]}}, err};
      end
      if (sample_tick && deriv_tick) begin
        d_term <= d_full[15:0];
        prev_err <= err;
      end
      // Sum one cycle later so the fresh accumulator is used
      if (out_tick) begin
        ctrl_out <= p_term + i_term + d_term;
      end
    end
  end
endmodule

// ===== rtl/servo_pid_host_port.v
`timescale 1ns/1ps
`include "servo_pid_map.vh"

module servo_pid_host_port #(
  parameter SAMPLE_CLKS = `SAMPLE_CLKS,
  parameter BUSY_CLKS = `BUSY_NS * `CLK_KHZ / 1000000,
  parameter WIDE_HOLD_CLKS = `WIDE_HOLD_CLKS
) (
  input wire sys_clk,
  input wire reset_n,
  input wire port_select_n,
  input wire read_n,
  input wire write_n,
  input wire [7:0] host_data_in,
  output reg [7:0] host_data_out,
  output wire host_data_oe_n,
  input wire quad_a,
  input wire quad_b,
  input wire index_n,
  output reg [7:0] motor_data,
  output reg motor_hi_half,
  output wire wide_output_select,
  output wire motion_active
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WRITE = 3'b010;
  localparam ST_READ = 3'b100;
  // Counter loads cut to the counter widths on purpose
  localparam integer BUSY_I = BUSY_CLKS;
  localparam integer SAMPLE_I = SAMPLE_CLKS - 1;
  localparam integer HOLD_I = WIDE_HOLD_CLKS;
  localparam [11:0] BUSY_LOAD = BUSY_I[11:0];
  localparam [10:0] SAMPLE_LAST = SAMPLE_I[10:0];
  localparam [4:0] WIDE_HOLD = HOLD_I[4:0];
  localparam [11:0] ZERO_WIDE = `ZERO12;

  // Number of set bits in a control field
  function [2:0] ones4;
    input [3:0] v;
    begin
      ones4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
    end
  endfunction

  // Pin synchronisers: {select, read, write, a, b, index}
  reg [5:0] pin_s1, pin_s2, pin_d;
  reg [7:0] bus_s1, bus_s2;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= 6'h3f;
      pin_s2 <= 6'h3f;
      pin_d <= 6'h3f;
      bus_s1 <= 8'h00;
      bus_s2 <= 8'h00;
    end else begin
      pin_s1 <= {port_select_n, read_n, write_n, quad_a, quad_b, index_n};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      bus_s1 <= host_data_in;
      bus_s2 <= bus_s1;
    end
  end
  wire sel_hi = pin_s2[5];
  wire rd_low = ~pin_s2[4];
  wire wr_rise = pin_s2[3] & ~pin_d[3];
  wire rd_rise = pin_s2[4] & ~pin_d[4];
  wire qa = pin_s2[2];
  wire qb = pin_s2[1];
  wire idx_low = ~pin_s2[0];

  reg [2:0] xfer_state;
  reg [7:0] cmd_q;
  reg [2:0] word_idx, word_total;
  reg byte_lo;
  reg [7:0] hi_byte;
  reg [15:0] xfer_word [0:6];
  reg commit_go;
  reg [11:0] busy_cnt;
  reg [7:0] status_bits;
  reg home_req, soft_clear, index_armed, wide_mode, motor_off, moving;
  reg halt_en;
  reg [15:0] halt_thr, alert_thr;
  reg [15:0] kp_buf, ki_buf, kd_buf, il_buf, kp, ki, kd, il;
  reg [7:0] ds_buf, ds;
  reg [31:0] acc_buf, vel_buf, pos_buf, desired_pos, bkpt, idx_pos;
  reg [31:0] act_pos, last_pos;
  reg [15:0] act_vel;
  reg sample_tick;
  wire deriv_tick;
  wire [15:0] ctrl_u, int_sum;

  wire busy = (busy_cnt != 12'h000);
  wire [7:0] status_byte = {status_bits[7:1], busy};
  assign wide_output_select = wide_mode;
  assign motion_active = moving;

  // Port drives the bus only while the host holds the read strobe low
  assign host_data_oe_n = ~rd_low;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_data_out <= 8'h00;
    end else if (!sel_hi) begin
      host_data_out <= status_byte;
    end else begin
      host_data_out <= byte_lo ? xfer_word[word_idx][7:0] : xfer_word[word_idx][15:8];
    end
  end

  // Word positions inside variable-length load blocks
  wire [15:0] c0 = xfer_word[0];
  wire [2:0] f_ki = 3'd1 + {2'b00, c0[`FC_KP]};
  wire [2:0] f_kd = f_ki + {2'b00, c0[`FC_KI]};
  wire [2:0] f_il = f_kd + {2'b00, c0[`FC_KD]};
  wire [2:0] t_vel = 3'd1 + {1'b0, c0[`TC_ACC], 1'b0};
  wire [2:0] t_pos = t_vel + {1'b0, c0[`TC_VEL], 1'b0};
  wire [2:0] nxt_idx = word_idx + 3'd1;
  wire [15:0] new_word = {hi_byte, bus_s2};
  wire [2:0] f_total = 3'd1 + ones4(new_word[3:0]);
  wire [2:0] t_ones = ones4({1'b0, new_word[`TC_ACC], new_word[`TC_VEL], new_word[`TC_POS]});
  wire [2:0] t_total = 3'd1 + {t_ones[1:0], 1'b0};

  // Position error and its saturation
  wire [31:0] err_full = desired_pos - act_pos;
  wire err_fits = (err_full[31:15] == 17'h0_0000) || (err_full[31:15] == 17'h1_ffff);
  wire [15:0] err16 = err_fits ? err_full[15:0] :
                      (err_full[31] ? `SAT_NEG : `SAT_POS);
  wire [15:0] err_mag = err16[15] ? (`CLR16 - err16) : err16;
  wire idx_hit = index_armed & ~qa & ~qb & idx_low;

  // Command decode, data steering, busy and status
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_state <= ST_IDLE;
      cmd_q <= `CMD_RESET;
      word_idx <= 3'd0;
      word_total <= 3'd0;
      byte_lo <= 1'b0;
      hi_byte <= 8'h00;
      commit_go <= 1'b0;
      busy_cnt <= 12'h000;
      status_bits <= 8'h00;
      home_req <= 1'b0;
      soft_clear <= 1'b0;
      index_armed <= 1'b0;
      wide_mode <= 1'b0;
      motor_off <= 1'b0;
      moving <= 1'b0;
      halt_en <= 1'b0;
      halt_thr <= `SAT_POS;
      alert_thr <= `SAT_POS;
      kp_buf <= `CLR16; ki_buf <= `CLR16; kd_buf <= `CLR16; il_buf <= `CLR16;
      kp <= `CLR16; ki <= `CLR16; kd <= `CLR16; il <= `CLR16;
      ds_buf <= 8'h00;
      ds <= 8'h00;
      acc_buf <= `CLR32; vel_buf <= `CLR32; pos_buf <= `CLR32;
      desired_pos <= `CLR32;
      bkpt <= `CLR32;
      idx_pos <= `CLR32;
    end else begin
      home_req <= 1'b0;
      soft_clear <= 1'b0;
      commit_go <= 1'b0;
      if (busy) begin
        busy_cnt <= busy_cnt - 12'h001;
      end
      // Host-side command byte
      if (wr_rise && !sel_hi && !busy) begin
        busy_cnt <= BUSY_LOAD;
        cmd_q <= bus_s2;
        word_idx <= 3'd0;
        byte_lo <= 1'b0;
        xfer_state <= ST_IDLE;
        case (bus_s2)
          `CMD_RESET: begin
            soft_clear <= 1'b1;
            home_req <= 1'b1;
            wide_mode <= 1'b0;
            motor_off <= 1'b0;
            moving <= 1'b0;
            halt_en <= 1'b0;
            index_armed <= 1'b0;
            kp_buf <= `CLR16; ki_buf <= `CLR16; kd_buf <= `CLR16; il_buf <= `CLR16;
            kp <= `CLR16; ki <= `CLR16; kd <= `CLR16; il <= `CLR16;
            acc_buf <= `CLR32; vel_buf <= `CLR32; pos_buf <= `CLR32;
            desired_pos <= `CLR32;
            status_bits <= 8'h00;
          end
          `CMD_BEGIN: begin
            desired_pos <= pos_buf;
            moving <= 1'b1;
            motor_off <= 1'b0;
          end
          `CMD_HOME: begin
            home_req <= 1'b1;
            desired_pos <= desired_pos - act_pos;
          end
          `CMD_INDEX_ARM: index_armed <= 1'b1;
          `CMD_FILTER_APPLY: begin
            kp <= kp_buf; ki <= ki_buf; kd <= kd_buf; il <= il_buf;
            ds <= ds_buf;
          end
          `CMD_NARROW: wide_mode <= 1'b0;
          `CMD_WIDE: wide_mode <= 1'b1;
          `CMD_DES_VEL, `CMD_DES_POS, `CMD_IDX_POS, `CMD_ACT_POS: begin
            xfer_state <= ST_READ;
            word_total <= 3'd2;
          end
          `CMD_ACT_VEL, `CMD_SIGNALS, `CMD_INT_SUM: begin
            xfer_state <= ST_READ;
            word_total <= 3'd1;
          end
          `CMD_HALT_THR, `CMD_ALERT_THR, `CMD_INT_MASK, `CMD_INT_CLEAR,
          `CMD_FILTER_LOAD, `CMD_TRAJ_LOAD: begin
            xfer_state <= ST_WRITE;
            word_total <= 3'd1;
          end
          `CMD_BKPT_ABS, `CMD_BKPT_REL: begin
            xfer_state <= ST_WRITE;
            word_total <= 3'd2;
          end
          default: xfer_state <= ST_IDLE;
        endcase
        // Snapshot the read-back source into the word buffer
        case (bus_s2)
          `CMD_DES_VEL: begin xfer_word[0] <= vel_buf[31:16]; xfer_word[1] <= vel_buf[15:0]; end
          `CMD_DES_POS: begin
            xfer_word[0] <= desired_pos[31:16];
            xfer_word[1] <= desired_pos[15:0];
          end
          `CMD_IDX_POS: begin xfer_word[0] <= idx_pos[31:16]; xfer_word[1] <= idx_pos[15:0]; end
          `CMD_ACT_POS: begin xfer_word[0] <= act_pos[31:16]; xfer_word[1] <= act_pos[15:0]; end
          `CMD_ACT_VEL: xfer_word[0] <= act_vel;
          `CMD_SIGNALS: xfer_word[0] <= {8'h00, status_byte};
          `CMD_INT_SUM: xfer_word[0] <= int_sum;
          default: xfer_word[6] <= xfer_word[6];
        endcase
      end
      // Data byte pairs, most significant first
      if (sel_hi && ((wr_rise && xfer_state == ST_WRITE) ||
                     (rd_rise && xfer_state == ST_READ))) begin
        byte_lo <= ~byte_lo;
        if (!byte_lo) begin
          hi_byte <= bus_s2;
        end else begin
          busy_cnt <= BUSY_LOAD;
          word_idx <= nxt_idx;
          if (xfer_state == ST_WRITE) begin
            xfer_word[word_idx] <= new_word;
            if (word_idx == 3'd0 && cmd_q == `CMD_FILTER_LOAD) begin
              word_total <= f_total;
              if (f_total == 3'd1) begin
                commit_go <= 1'b1;
                xfer_state <= ST_IDLE;
              end
            end else if (word_idx == 3'd0 && cmd_q == `CMD_TRAJ_LOAD) begin
              word_total <= t_total;
              if (t_total == 3'd1) begin
                commit_go <= 1'b1;
                xfer_state <= ST_IDLE;
              end
            end else if (nxt_idx == word_total) begin
              commit_go <= 1'b1;
              xfer_state <= ST_IDLE;
            end
          end else if (nxt_idx == word_total) begin
            xfer_state <= ST_IDLE;
          end
        end
      end
      // Apply a completed load block to its buffers
      if (commit_go) begin
        case (cmd_q)
          `CMD_HALT_THR: begin halt_thr <= c0; halt_en <= 1'b1; end
          `CMD_ALERT_THR: alert_thr <= c0;
          `CMD_INT_CLEAR: status_bits <= status_bits & c0[7:0];
          `CMD_FILTER_LOAD: begin
            ds_buf <= c0[15:8];
            if (c0[`FC_KP]) kp_buf <= xfer_word[1];
            if (c0[`FC_KI]) ki_buf <= xfer_word[f_ki];
            if (c0[`FC_KD]) kd_buf <= xfer_word[f_kd];
            if (c0[`FC_IL]) il_buf <= xfer_word[f_il];
          end
          `CMD_TRAJ_LOAD: begin
            if (c0[`TC_ACC]) acc_buf <= {xfer_word[1], xfer_word[2]};
            if (c0[`TC_VEL]) vel_buf <= {xfer_word[t_vel], xfer_word[t_vel + 3'd1]};
            if (c0[`TC_POS]) pos_buf <= {xfer_word[t_pos], xfer_word[t_pos + 3'd1]};
          end
          `CMD_BKPT_ABS: bkpt <= {c0, xfer_word[1]};
          `CMD_BKPT_REL: bkpt <= act_pos + {c0, xfer_word[1]};
          default: halt_en <= halt_en;
        endcase
      end
      // Hardware events set after any clear, so a set is never lost
      if (idx_hit) begin
        idx_pos <= act_pos;
        index_armed <= 1'b0;
        status_bits[`ST_INDEX] <= 1'b1;
      end
      if (err_mag > alert_thr) begin
        status_bits[`ST_ERR] <= 1'b1;
      end
      if (halt_en && err_mag > halt_thr) begin
        status_bits[`ST_ERR] <= 1'b1;
        status_bits[`ST_OFF] <= 1'b1;
        motor_off <= 1'b1;
      end
      if (act_pos == bkpt) begin
        status_bits[`ST_BKPT] <= 1'b1;
      end
    end
  end

  // Quadrature counter, four counts per line
  wire pa = pin_d[2];
  wire pb = pin_d[1];
  wire a_chg = qa ^ pa;
  wire b_chg = qb ^ pb;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_pos <= `CLR32;
      last_pos <= `CLR32;
      act_vel <= `CLR16;
    end else begin
      if (home_req) begin
        act_pos <= `CLR32;
      end else if ((a_chg ^ b_chg) && (qa ^ pb)) begin
        act_pos <= act_pos + 32'h0000_0001;
      end else if (a_chg ^ b_chg) begin
        act_pos <= act_pos - 32'h0000_0001;
      end
      if (sample_tick) begin
        last_pos <= act_pos;
        act_vel <= act_pos[15:0] - last_pos[15:0];
      end
    end
  end

  // Sample and derivative interval timers
  reg [10:0] sample_cnt;
  reg [7:0] deriv_cnt;
  assign deriv_tick = (deriv_cnt == ds);
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_cnt <= 11'h000;
      deriv_cnt <= 8'h00;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= (sample_cnt == SAMPLE_LAST);
      sample_cnt <= (sample_cnt == SAMPLE_LAST) ? 11'h000 : sample_cnt + 11'h001;
      if (sample_tick) begin
        deriv_cnt <= deriv_tick ? 8'h00 : deriv_cnt + 8'h01;
      end
    end
  end

  pid_filter u_pid (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(soft_clear),
    .sample_tick(sample_tick),
    .deriv_tick(deriv_tick),
    .err(err16),
    .proportional_gain(kp),
    .integral_gain(ki),
    .derivative_gain(kd),
    .integral_limit(il),
    .ctrl_out(ctrl_u),
    .integral_sum(int_sum)
  );

  // Offset-binary codes; a halted motor sees half scale
  wire [15:0] u_eff = motor_off ? `CLR16 : ctrl_u;
  wire [7:0] code8 = {u_eff[15:8]} ^ `ZERO8;
  wire [11:0] code12 = u_eff[15:4] ^ `ZERO12;

  // Wide zero is shown for a while after reset before narrow mode
  reg [4:0] wide_hold;
  reg mux_phase;
  wire show_wide = wide_mode | (wide_hold != 5'h00);
  wire [11:0] wide_code = (wide_hold != 5'h00) ? `ZERO12 : code12;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wide_hold <= WIDE_HOLD;
      mux_phase <= 1'b1;
      motor_data <= {2'b00, ZERO_WIDE[11:6]};
      motor_hi_half <= 1'b1;
    end else begin
      if (soft_clear) begin
        wide_hold <= WIDE_HOLD;
      end else if (wide_hold != 5'h00) begin
        wide_hold <= wide_hold - 5'h01;
      end
      mux_phase <= ~mux_phase;
      // Two six-bit halves alternate, the select tells the latch
      if (show_wide) begin
        motor_data <= {2'b00, mux_phase ? wide_code[11:6] : wide_code[5:0]};
        motor_hi_half <= mux_phase;
      end else begin
        motor_data <= code8;
        motor_hi_half <= 1'b0;
      end
    end
  end
endmodule

// ===== sim/servo_pid_host_port_asserts.sv
`timescale 1ns/1ps
module servo_pid_host_port_asserts #(
  parameter SAMPLE_CLKS = 2048,
  parameter BUSY_CLKS = 800,
  parameter WIDE_HOLD_CLKS = 16
) (
  input wire sys_clk,
  input wire reset_n,
  input wire port_select_n,
  input wire read_n,
  input wire write_n,
  input wire [7:0] host_data_out,
  input wire host_data_oe_n,
  input wire [7:0] motor_data,
  input wire motor_hi_half,
  input wire wide_output_select,
  input wire motion_active
);
  logic [5:0] since_rst;
  logic [12:0] since_strobe;
  // Age counters; both saturate so a long idle spell never wraps
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_rst <= 6'h00;
      since_strobe <= 13'h0000;
    end else begin
      if (since_rst != 6'h3f) since_rst <= since_rst + 6'h01;
      if (!write_n || (!read_n && port_select_n)) since_strobe <= 13'h0000;
      else if (since_strobe != 13'h1fff) since_strobe <= since_strobe + 13'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Status strobe held long enough for the synchronised reply
  sequence status_read;
    (!port_select_n && !read_n) [*5];
  endsequence
  oe_follow_a: assert property (!read_n [*4] |-> !host_data_oe_n)
    else $error("drive enable not low during read");
  oe_release_a: assert property (read_n [*4] |-> host_data_oe_n)
    else $error("drive enable low without read");
  status_spare_a: assert property (
    status_read |-> host_data_out[4] == 1'b0 && host_data_out[2:1] == 2'b00)
    else $error("spare status bits not zero");
  busy_bound_a: assert property (status_read ##0 host_data_out[0] |-> since_strobe <= 13'h0fa0)
    else $error("busy flag held too long");
  // A reset command replays the wide zero, so a high select may only carry its upper half
  narrow_half_a: assert property (
    since_rst == 6'h3f && !wide_output_select && !$past(wide_output_select) && motor_hi_half
    |-> motor_data == 8'h20)
    else $error("half select active in narrow mode");
  wide_upper_a: assert property (wide_output_select && $past(wide_output_select) |-> motor_data[7:6] == 2'b00)
    else $error("wide half carries upper bits");
  hold_code_a: assert property (since_rst < WIDE_HOLD_CLKS - 2 |-> motor_data == (motor_hi_half ? 8'h20 : 8'h00))
    else $error("reset code not half scale");
  width_cmd_a: assert property ($changed(wide_output_select) |-> $past(port_select_n, 3) == 1'b0)
    else $error("width changed without command");
  motion_cmd_a: assert property (
    $rose(motion_active) |-> $past(port_select_n, 3) == 1'b0 && $past(write_n, 3))
    else $error("motion started without command");
endmodule
bind servo_pid_host_port servo_pid_host_port_asserts #(
  .SAMPLE_CLKS(SAMPLE_CLKS),
  .BUSY_CLKS(BUSY_CLKS),
  .WIDE_HOLD_CLKS(WIDE_HOLD_CLKS)
) i_servo_pid_host_port_asserts (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .port_select_n(port_select_n),
  .read_n(read_n),
  .write_n(write_n),
  .host_data_out(host_data_out),
  .host_data_oe_n(host_data_oe_n),
  .motor_data(motor_data),
  .motor_hi_half(motor_hi_half),
  .wide_output_select(wide_output_select),
  .motion_active(motion_active)
);

// ===== sim/host_cpu_model.sv
`timescale 1ns/1ps
// Host processor on the byte port; everything moves 1 ns after a rising edge
module host_cpu_model (
  input wire sys_clk,
  input wire [7:0] host_data_out,
  output logic port_select_n,
  output logic read_n,
  output logic write_n,
  output logic [7:0] host_data_in
);
  initial begin
    port_select_n = 1'b0;
    read_n = 1'b1;
    write_n = 1'b1;
    host_data_in = 8'h5a;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Data outlives the strobe because the port synchronises both alike
  task automatic put(input logic sel_n, input logic [7:0] b);
    port_select_n = sel_n;
    host_data_in = b;
    write_n = 1'b0;
    cyc(2);
    write_n = 1'b1;
    cyc(4);
    host_data_in = ~b; // Released bus shows no stale byte
  endtask
  task automatic get(input logic sel_n, output logic [7:0] b);
    port_select_n = sel_n;
    read_n = 1'b0;
    cyc(5);
    b = host_data_out;
    read_n = 1'b1;
    cyc(3);
  endtask
  // Bounded poll so a stuck flag cannot hang the host
  task automatic wait_ready();
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++) get(1'b0, s);
  endtask
  task automatic command(input logic [7:0] c);
    wait_ready();
    put(1'b0, c);
  endtask
  task automatic send_word(input logic [15:0] w);
    wait_ready();
    put(1'b1, w[15:8]);
    put(1'b1, w[7:0]);
  endtask
  task automatic fetch_word(output logic [15:0] w);
    wait_ready();
    get(1'b1, w[15:8]);
    get(1'b1, w[7:0]);
  endtask
endmodule

// ===== sim/servo_pid_host_port_test.sv
`timescale 1ns/1ps
`include "servo_pid_map.vh"
module servo_pid_host_port_test;
  localparam int SAMPLES = 64;
  logic sys_clk, reset_n, quad_a, quad_b, index_n;
  wire port_select_n, read_n, write_n, host_data_oe_n;
  wire motor_hi_half, wide_output_select, motion_active;
  wire [7:0] host_data_in, host_data_out, motor_data;
  logic [31:0] pos;
  int err_total, num_checks;
  servo_pid_host_port #(.SAMPLE_CLKS(SAMPLES)) i_servo_pid_host_port (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .port_select_n(port_select_n),
    .read_n(read_n),
    .write_n(write_n),
    .host_data_in(host_data_in),
    .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n),
    .quad_a(quad_a),
    .quad_b(quad_b),
    .index_n(index_n),
    .motor_data(motor_data),
    .motor_hi_half(motor_hi_half),
    .wide_output_select(wide_output_select),
    .motion_active(motion_active)
  );
  host_cpu_model host (
    .sys_clk(sys_clk),
    .host_data_out(host_data_out),
    .port_select_n(port_select_n),
    .read_n(read_n),
    .write_n(write_n),
    .host_data_in(host_data_in)
  );
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset_state();
    check("rst code", motor_data, 8'h20);
    check("rst half", motor_hi_half, 1'b1);
    check("oe_n", host_data_oe_n, 1'b1);
    check("wide", wide_output_select, 1'b0);
    check("motion", motion_active, 1'b0);
    host.cyc(24);
    check("zero8", motor_data, `ZERO8);
    check("half", motor_hi_half, 1'b0);
  endtask
  // A width change sent while busy must leave no trace
  task automatic t_busy();
    logic [7:0] s;
    int n;
    host.command(`CMD_HOME);
    host.get(1'b0, s);
    check("busy set", s[0], 1'b1);
    host.put(1'b0, `CMD_WIDE);
    host.cyc(4);
    check("width kept", wide_output_select, 1'b0);
    n = 0;
    while (s[0] !== 1'b0 && n < 1000) begin
      host.get(1'b0, s);
      n++;
    end
    check("busy span", n * 8 <= 4000, 1'b1);
  endtask
  task automatic t_width();
    logic [11:0] code;
    host.command(`CMD_WIDE);
    check("wide on", wide_output_select, 1'b1);
    code = 12'h000;
    repeat (40) begin
      host.cyc(1);
      if (motor_hi_half === 1'b1) code[11:6] = motor_data[5:0];
      else code[5:0] = motor_data[5:0];
    end
    check("zero12", code, `ZERO12);
    host.command(`CMD_NARROW);
    check("wide off", wide_output_select, 1'b0);
  endtask
  // Two full encoder cycles, phase A leading, then read the count back
  task automatic t_position();
    logic [15:0] hi, lo;
    logic [7:0] s;
    repeat (2) begin
      quad_a = 1'b1;
      host.cyc(4);
      quad_b = 1'b1;
      host.cyc(4);
      quad_a = 1'b0;
      host.cyc(4);
      quad_b = 1'b0;
      host.cyc(4);
    end
    // Both phases low now, so an index pulse is captured
    host.command(`CMD_INDEX_ARM);
    index_n = 1'b0;
    host.cyc(4);
    index_n = 1'b1;
    host.get(1'b0, s);
    check("index flag", s[`ST_INDEX], 1'b1);
    host.command(`CMD_ACT_POS);
    host.fetch_word(hi);
    host.get(1'b0, s);
    check("busy after word", s[0], 1'b1);
    host.fetch_word(lo);
    pos = {hi, lo};
    check("four per line", pos == 32'h0000_0008 || pos == 32'hffff_fff8, 1'b1);
  endtask
  // Gain 0x0100 on an error of eight counts moves the code eight steps
  task automatic t_filter();
    host.command(`CMD_FILTER_LOAD);
    host.send_word(16'h0008);
    host.send_word(16'h0100);
    host.command(`CMD_FILTER_APPLY);
    host.cyc(3 * SAMPLES);
    check("p term", motor_data, pos[31] ? 8'h88 : 8'h78);
  endtask
  // Velocity 2.5 counts per sample goes in scaled by 65536; target 0x10
  task automatic t_motion();
    logic [15:0] hi, lo;
    host.command(`CMD_TRAJ_LOAD);
    host.send_word(16'h000a);
    host.send_word(16'h0002);
    host.send_word(16'h8000);
    host.send_word(16'h0000);
    host.send_word(16'h0010);
    host.command(`CMD_DES_VEL);
    host.fetch_word(hi);
    host.fetch_word(lo);
    check("velocity", {hi, lo}, 32'h0002_8000);
    host.command(`CMD_BEGIN);
    check("moving", motion_active, 1'b1);
    host.command(`CMD_DES_POS);
    host.fetch_word(hi);
    host.fetch_word(lo);
    check("target", {hi, lo}, 32'h0000_0010);
    host.command(`CMD_RESET);
    check("stopped", motion_active, 1'b0);
    host.cyc(3 * SAMPLES);
    check("reset zero", motor_data, `ZERO8);
  endtask
  initial begin
    err_total = 0;
    num_checks = 0;
    reset_n = 1'b0;
    quad_a = 1'b0;
    quad_b = 1'b0;
    index_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    t_reset_state();
    t_busy();
    t_width();
    t_position();
    t_filter();
    t_motion();
    final_report();
  end
  // Whole run needs well under a millisecond
  initial begin
    #2_000_000;
    err_total++;
    final_report();
  end
endmodule
